// file: dv/lpc_ee_model.sv
// Purpose: EEPROM model on the product data cycle port.
// Assumes: One acknowledge pulse per cycle after a chosen delay.
// Notes:   Idle read data toggles so a stale word is never taken.
`timescale 1ns/1ps
`default_nettype none
module lpc_ee_model (
    // Clock
    input  wire logic        clk_sys,
    // Cycle port
    input  wire logic        eeReq,
    input  wire logic        eeWrite,
    input  wire logic [5:0]  eeAddr,
    input  wire logic [31:0] eeWdata,
    output logic             eeAck,
    output logic [31:0]      eeRdata,
    // Answer delay in cycles
    input  wire logic [4:0]  delay
);
    logic [31:0] mem [64];
    int          cnt;
    initial begin
        eeAck = 1'b0;
        eeRdata = 32'h0;
        cnt = 0;
        for (int i = 0; i < 64; i++) begin
            mem[i] = {4{2'b10, 6'(i)}};
        end
    end
    always @(posedge clk_sys) begin
        eeAck <= 1'b0;
        eeRdata <= ~eeRdata;
        if (eeReq && !eeAck) begin
            if (cnt >= delay) begin
                cnt <= 0;
                eeAck <= 1'b1;
                eeRdata <= mem[eeAddr];
                if (eeWrite) mem[eeAddr] <= eeWdata;
            end else cnt <= cnt + 1;
        end
    end
endmodule : lpc_ee_model
`default_nettype wire

// file: dv/lpc_regs_chk.sv
// Purpose: Port assertions for the lpc_regs register slice.
// Assumes: Read data stands in the cycle waitrequest is low.
// Notes:   Related ports share a line to keep the file short.
`timescale 1ns/1ps
`default_nettype none
module lpc_regs_chk
    import lpc_pkg::*;
(
    // Clock, reset and bus
    input wire logic              clk_sys, nrst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read, avs_write, avs_waitrequest,
    input wire logic [31:0]       avs_writedata, avs_readdata,
    input wire logic [3:0]        avs_byteenable,
    // Phy controls
    input wire logic              hotResetEn, loopbackEn, crossLinkEn,
    input wire logic [2:0]        laneNegTries,
    input wire logic [15:0]       l1EntryTimer,
    input wire logic [7:0]        cdrRecoveryFts, ftsCommaSym, ftsFillSym,
    input wire logic [9:0]        cdrRecoverySymbols,
    input wire logic [6:0]        l0sExitLatency, l1ExitLatency,
    input wire logic              powerDownWaitEn,
    // EEPROM port
    input wire logic              eeReq, eeWrite, eeAck,
    input wire logic [5:0]        eeAddr
);
    import lpc_pkg::*;
    logic wrAcc;
    logic rdAcc;
    assign wrAcc = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
    assign rdAcc = avs_read && !avs_waitrequest;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_one_wait: assert property ($rose(avs_read || avs_write)
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus access without exactly one wait state");
    a_fts_shape: assert property (
        ftsCommaSym == 8'hBC && ftsFillSym == 8'h3C
        && cdrRecoverySymbols == {cdrRecoveryFts, 2'b00})
        else $error("training set symbols wrong");
    a_cfg0_write: assert property (
        wrAcc && avs_address == 9'h0CC |=> {l1EntryTimer, laneNegTries,
        crossLinkEn, loopbackEn, hotResetEn} == {$past(avs_writedata[31:16]),
        $past(avs_writedata[7:5]), $past(avs_writedata[2:0])})
        else $error("config 0 outputs do not follow write");
    a_cfg2_write: assert property (
        wrAcc && avs_address == 9'h0D4 |=> {powerDownWaitEn, l1ExitLatency,
        l0sExitLatency, cdrRecoveryFts} == {$past(avs_writedata[23:16]),
        $past(avs_writedata[14:0])})
        else $error("config 2 outputs do not follow write");
    a_link_fixed: assert property (
        rdAcc && avs_address == 9'h0C0 |-> avs_readdata[31:30] == 2'b00
        && avs_readdata[28] && avs_readdata[15:0] == 16'h0000)
        else $error("link status fixed bits wrong");
    a_cap_header: assert property (
        rdAcc && avs_address == 9'h0D8 |-> avs_readdata[15:0] == 16'hF003
        && avs_readdata[30:24] == 7'h00 && avs_readdata[17:16] == 2'b00)
        else $error("capability header wrong");
    a_ee_launch: assert property (
        wrAcc && avs_address == 9'h0D8 && !eeReq |=> eeReq
        && eeWrite == $past(avs_writedata[31])
        && eeAddr == $past(avs_writedata[23:18]))
        else $error("EEPROM cycle not launched as written");
    a_ee_hold: assert property (
        eeReq && !eeAck |=> eeReq && $stable(eeWrite) && $stable(eeAddr))
        else $error("EEPROM request changed before acknowledge");
    a_ee_end: assert property (
        eeReq && eeAck |=> !eeReq)
        else $error("EEPROM request held after acknowledge");
    a_op_busy: assert property (
        rdAcc && avs_address == 9'h0D8 && eeReq && $past(eeReq)
        |-> avs_readdata[31] == eeWrite)
        else $error("operation bit changed while cycle busy");
endmodule : lpc_regs_chk
bind lpc_regs lpc_regs_chk lpc_regs_chk_inst (.clk_sys, .nrst,
    .avs_address, .avs_read, .avs_write, .avs_waitrequest, .avs_writedata,
    .avs_readdata, .avs_byteenable, .hotResetEn, .loopbackEn, .crossLinkEn,
    .laneNegTries, .l1EntryTimer, .cdrRecoveryFts, .ftsCommaSym,
    .ftsFillSym, .cdrRecoverySymbols, .l0sExitLatency, .l1ExitLatency,
    .powerDownWaitEn, .eeReq, .eeWrite, .eeAck, .eeAddr);
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for lpc_regs with an EEPROM model.
// Assumes: Avalon master samples waitrequest just before each edge.
// Notes:   Reads note expectations in a queue; a monitor compares.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lpc_pkg::*;
    logic clk_sys, nrst, avsRead, avsWrite, avsWaitrequest, irq;
    logic [8:0]  avsAddress;
    logic [31:0] avsWritedata, avsReaddata, lastRd, d, m, eeWdata, eeRdata;
    logic [3:0]  avsByteenable, linkSpeed;
    logic [5:0]  linkWidth, eeAddr, a;
    logic trainErr, training, inactive, eeReq, eeWrite, eeAck;
    logic [4:0]  eeDelay;
    logic [31:0] expQ[$], mskQ[$], sh[3];
    int n_fail, n_checks;
    lpc_regs lpc_regs_inst (.clk_sys(clk_sys), .nrst(nrst),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
        .linkSpeedIn(linkSpeed), .linkWidthIn(linkWidth),
        .linkTrainErrIn(trainErr), .linkTrainingIn(training),
        .linkInactiveIn(inactive), .hotResetEn(), .loopbackEn(),
        .crossLinkEn(), .laneNegTries(), .l1EntryTimer(), .lifetimeTimers(),
        .cdrRecoveryFts(), .cdrRecoverySymbols(), .ftsCommaSym(),
        .ftsFillSym(), .l0sExitLatency(), .l1ExitLatency(),
        .polarityInvEn(), .powerDownWaitEn(), .eeReq(eeReq),
        .eeWrite(eeWrite), .eeAddr(eeAddr), .eeWdata(eeWdata),
        .eeAck(eeAck), .eeRdata(eeRdata), .irq(irq));
    lpc_ee_model lpc_ee_model_inst (.clk_sys(clk_sys), .eeReq(eeReq),
        .eeWrite(eeWrite), .eeAddr(eeAddr), .eeWdata(eeWdata),
        .eeAck(eeAck), .eeRdata(eeRdata), .delay(eeDelay));

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            n_fail++;
        end
    endtask : check
    task final_report;
        if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // One edge first, so a release and a new request never share a step
    task automatic bus(input logic [8:0] ad, input logic wr,
                       input logic [31:0] wd, input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avsAddress <= ad;
        avsWritedata <= wd;
        avsByteenable <= be;
        avsRead <= !wr;
        avsWrite <= wr;
        n = 0;
        @(negedge clk_sys);
        while (avsWaitrequest !== 1'b0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 100) n_fail++;
        lastRd = avsReaddata;
        @(posedge clk_sys);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : bus
    task automatic rd(input logic [8:0] ad, input logic [31:0] e,
                      input logic [31:0] msk);
        expQ.push_back(e);
        mskQ.push_back(msk);
        bus(ad, 1'b0, 32'h0, 4'hF);
    endtask : rd
    task automatic poll(input logic v);
        for (int n = 0; n < 100; n++) begin
            rd(9'h0D8, 32'h0, 32'h0);
            if (lastRd[31] === v) break;
        end
        check({31'h0, lastRd[31]}, {31'h0, v});
    endtask : poll
    function automatic logic [31:0] link_exp();
        return {2'b00, inactive, 1'b1, training, trainErr, linkWidth,
                linkSpeed, 16'h0000};
    endfunction : link_exp
    function automatic logic [31:0] cap(input logic op, input logic [5:0] x);
        return {op, 7'h00, x, 2'b00, 16'hF003};
    endfunction : cap
    always @(negedge clk_sys) begin
        if (avsRead && avsWaitrequest === 1'b0 && expQ.size() > 0) begin
            m = mskQ.pop_front();
            check(avsReaddata & m, expQ.pop_front() & m);
        end
    end

    // ************************************************************
    // Clock, reset, watchdog and scenarios
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    initial begin
        void'($urandom(24011));
        {avsRead, avsWrite, trainErr, training, inactive} = 5'h00;
        {avsAddress, avsWritedata, avsByteenable} = '0;
        linkSpeed = 4'h1;
        linkWidth = 6'h01;
        eeDelay = 5'h02;
        nrst = 1'b0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd(9'h0C0, 32'h1011_0000, '1);
        rd(9'h0CC, 32'h0400_1060, '1);
        rd(9'h0D0, 32'h0400_0800, '1);
        rd(9'h0D4, 32'h0099_8254, '1);
        rd(9'h0D8, 32'h0000_F003, '1);
        rd(9'h0DC, 32'h0, '1);
        rd(9'h1F4, 32'h0, '1);
        for (int i = 0; i < 4; i++) begin
            linkSpeed <= 4'($urandom);
            linkWidth <= 6'($urandom);
            {trainErr, training, inactive} <= 3'($urandom);
            repeat (2) @(posedge clk_sys);
            rd(9'h0C0, link_exp(), '1);
        end
        bus(9'h0C0, 1'b1, 32'hFFFF_FFFF, 4'hF);
        rd(9'h0C0, link_exp(), '1);
        bus(9'h100, 1'b1, 32'hFFFF_FFFF, 4'hF);
        rd(9'h100, 32'h0, '1);
        sh = '{32'h0400_1060, 32'h0400_0800, 32'h0099_8254};
        for (int i = 0; i < 12; i++) begin
            d = $urandom;
            m = (i < 3) ? 32'hFFFF_FFFF : {{8{1'($urandom)}},
                {8{1'($urandom)}}, {8{1'($urandom)}}, {8{1'($urandom)}}};
            bus(9'h0CC + 9'(4 * (i % 3)), 1'b1, d,
                {m[24], m[16], m[8], m[0]});
            sh[i % 3] = (sh[i % 3] & ~m) | (d & m);
            if (i % 3 == 2) sh[2] = sh[2] & 32'h00FF_FFFF;
            rd(9'h0CC + 9'(4 * (i % 3)), sh[i % 3], '1);
        end
        bus(9'h0D8, 1'b1, 32'h7FFF_FFFF, 4'h7);
        rd(9'h0D8, cap(1'b0, 6'h3F), '1);
        for (int i = 0; i < 4; i++) begin
            a = 6'($urandom);
            eeDelay <= 5'($urandom % 16);
            bus(9'h0D8, 1'b1, {8'h00, a, 18'h0}, 4'hF);
            poll(1'b1);
            rd(9'h0DC, {4{2'b10, a}}, '1);
            rd(9'h0EC, {4{2'b10, a}}, '1);
        end
        d = $urandom;
        eeDelay <= 5'd20;
        bus(9'h0DC, 1'b1, d, 4'hF);
        bus(9'h0D8, 1'b1, {8'h80, a, 18'h0}, 4'hF);
        bus(9'h0D8, 1'b1, {8'h00, ~a, 18'h0}, 4'hF);
        rd(9'h0D8, cap(1'b1, a), '1);
        poll(1'b0);
        bus(9'h0D8, 1'b1, {8'h00, a, 18'h0}, 4'hF);
        poll(1'b1);
        rd(9'h0DC, d, '1);
        rd(9'h1F0, 32'h3, 32'h3);
        check({31'h0, irq}, 32'h0);
        bus(9'h1F4, 1'b1, 32'h1, 4'hF);
        repeat (2) @(negedge clk_sys);
        check({31'h0, irq}, 32'h1);
        bus(9'h1F0, 1'b1, 32'h7, 4'hF);
        repeat (2) @(negedge clk_sys);
        check({31'h0, irq}, 32'h0);
        rd(9'h1F0, 32'h0, '1);
        bus(9'h1F4, 1'b1, 32'h4, 4'hF);
        inactive <= ~inactive;
        repeat (4) @(negedge clk_sys);
        check({31'h0, irq}, 32'h1);
        bus(9'h1F0, 1'b1, 32'h4, 4'hF);
        repeat (2) @(negedge clk_sys);
        check({31'h0, irq}, 32'h0);
        repeat (2) @(posedge clk_sys);
        final_report();
    end
endmodule : tb
`default_nettype wire

// file: hw/lpc_pkg.sv
// Purpose: Constants for the link status, phy link config and product data
//          register slice.
// Assumes: 32-bit Avalon-MM register port, byte addressed.
// Notes:   Config and data reset values are whole-word images of the field defaults.
package lpc_pkg;

    // ************************************************************
    // Bus and map
    // ************************************************************
    localparam int unsigned ADDR_W = 9;
    localparam logic [8:0] OFF_LINK_STATUS = 9'h0C0;
    localparam logic [8:0] OFF_PHY_CFG0    = 9'h0CC;
    localparam logic [8:0] OFF_PHY_CFG1    = 9'h0D0;
    localparam logic [8:0] OFF_PHY_CFG2    = 9'h0D4;
    localparam logic [8:0] OFF_PD_CAP      = 9'h0D8;
    localparam logic [8:0] OFF_PD_DATA     = 9'h0DC;
    localparam logic [8:0] OFF_PD_DATA_ALT = 9'h0EC;
    localparam logic [8:0] OFF_IRQ_STATUS  = 9'h1F0;
    localparam logic [8:0] OFF_IRQ_MASK    = 9'h1F4;

    // ************************************************************
    // Reset values and writable masks
    // ************************************************************
    localparam logic [31:0] PHY_CFG0_RST  = 32'h0400_1060;
    localparam logic [31:0] PHY_CFG1_RST  = 32'h0400_0800;
    localparam logic [31:0] PHY_CFG2_RST  = 32'h0099_8254;
    localparam logic [31:0] PHY_CFG2_WMSK = 32'h00FF_FFFF;
    localparam logic [31:0] PD_DATA_RST   = 32'h0000_0000;
    localparam logic [3:0]  LINK_SPEED_RST = 4'h1;
    localparam logic [5:0]  LINK_WIDTH_RST = 6'h01;
    localparam logic        SLOT_CLK_CFG   = 1'b1;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned C0_HOT_RST   = 0;
    localparam int unsigned C0_LOOPBACK  = 1;
    localparam int unsigned C0_XLINK     = 2;
    localparam int unsigned C0_NEG_LSB   = 5;
    localparam int unsigned C0_L1T_LSB   = 16;
    localparam int unsigned C2_CDR_LSB   = 0;
    localparam int unsigned C2_L0S_LSB   = 8;
    localparam int unsigned C2_POL_INV   = 15;
    localparam int unsigned C2_L1_LSB    = 16;
    localparam int unsigned C2_PD_WAIT   = 23;
    localparam int unsigned PD_ADDR_LSB  = 18;
    localparam int unsigned PD_OP_BIT    = 31;
    localparam logic [7:0]  PD_CAP_ID    = 8'h03;
    localparam logic [7:0]  PD_NEXT_PTR  = 8'hF0;

    // ************************************************************
    // Training symbols and interrupt bits
    // ************************************************************
    localparam logic [7:0] SYM_COMMA     = 8'hBC;
    localparam logic [7:0] SYM_FTS       = 8'h3C;
    localparam logic [2:0] FTS_SYMBOLS   = 3'h4;
    localparam int unsigned IRQ_W        = 3;
    localparam int unsigned IRQ_RD_DONE  = 0;
    localparam int unsigned IRQ_WR_DONE  = 1;
    localparam int unsigned IRQ_LINK_CHG = 2;

    typedef enum logic [0:0] {
        PD_IDLE = 1'b0,
        PD_BUSY = 1'b1
    } lpc_pd_state_type;

endpackage : lpc_pkg

// file: hw/lpc_regs.sv
// Purpose: Link status, phy link config and product data capability
//          registers with the EEPROM read/write launch handshake.
// Assumes: One clock; link state inputs synchronous to clk_sys.
// Notes:   One wait state on every bus access.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module lpc_regs
    import lpc_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]     avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Link state from the training logic
    input  wire logic [3:0]            linkSpeedIn,
    input  wire logic [5:0]            linkWidthIn,
    input  wire logic                  linkTrainErrIn,
    input  wire logic                  linkTrainingIn,
    input  wire logic                  linkInactiveIn,
    // Phy link controls
    output logic                       hotResetEn,
    output logic                       loopbackEn,
    output logic                       crossLinkEn,
    output logic      [2:0]            laneNegTries,
    output logic      [15:0]           l1EntryTimer,
    output logic      [31:0]           lifetimeTimers,
    output logic      [7:0]            cdrRecoveryFts,
    output logic      [9:0]            cdrRecoverySymbols,
    output logic      [7:0]            ftsCommaSym,
    output logic      [7:0]            ftsFillSym,
    output logic      [6:0]            l0sExitLatency,
    output logic      [6:0]            l1ExitLatency,
    output logic                       polarityInvEn,
    output logic                       powerDownWaitEn,
    // EEPROM cycle port
    output logic                       eeReq,
    output logic                       eeWrite,
    output logic      [5:0]            eeAddr,
    output logic      [31:0]           eeWdata,
    input  wire logic                  eeAck,
    input  wire logic [31:0]           eeRdata,
    // Interrupt
    output logic                       irq
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic             rstSync1_reg;
    logic             rstSync2_reg;
    logic             rstN;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstSync1_reg <= 1'b0;
            rstSync2_reg <= 1'b0;
        end else begin
            rstSync1_reg <= 1'b1;
            rstSync2_reg <= rstSync1_reg;
        end
    end
    assign rstN = rstSync2_reg;

    // Everything below runs from the released copy


    // ************************************************************
    // Declarations
    // ************************************************************
    logic             ack_reg;
    logic [31:0]      rdata_reg;
    logic [31:0]      rdata_next;
    logic             wrEn;
    logic [3:0]       linkSpeed_reg;
    logic [5:0]       linkWidth_reg;
    logic             trainErr_reg;
    logic             training_reg;
    logic             inactive_reg;
    logic [31:0]      cfg0_reg;
    logic [31:0]      cfg1_reg;
    logic [31:0]      cfg2_reg;
    logic             pdOp_reg;
    logic [5:0]       pdAddr_reg;
    logic [31:0]      pdData_reg;
    lpc_pd_state_type pdState_reg;
    logic             pdLaunch;
    logic             pdDone;
    logic [IRQ_W-1:0] irqStatus_reg;
    logic [IRQ_W-1:0] irqMask_reg;
    logic [IRQ_W-1:0] irqEvent;
    logic [31:0]      linkWord;
    logic [31:0]      pdCapWord;

    // Byte-lane merge, limited to writable bits
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  be,
        input logic [31:0] wmask
    );
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        return (oldVal & ~m) | (newVal & m);
    endfunction : mergeBytes

    // Shared address match for the read mux and write strobes
    function automatic logic hit(input logic [ADDR_W-1:0] off);
        return avs_address == off;
    endfunction : hit

    // ************************************************************
    // Bus handshake
    // ************************************************************
    // Every access waits one cycle; read data is built in that cycle
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wrEn            = avs_write & ack_reg;

    // A held request gets a fresh wait state


    // ************************************************************
    // Link status capture
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            linkSpeed_reg <= LINK_SPEED_RST;
            linkWidth_reg <= LINK_WIDTH_RST;
            trainErr_reg  <= 1'b0;
            training_reg  <= 1'b0;
            inactive_reg  <= 1'b0;
        end else begin
            linkSpeed_reg <= linkSpeedIn;
            linkWidth_reg <= linkWidthIn;
            trainErr_reg  <= linkTrainErrIn;
            training_reg  <= linkTrainingIn;
            inactive_reg  <= linkInactiveIn;
        end
    end

    // Low half belongs to link control, outside this slice
    assign linkWord = {2'b00, inactive_reg, SLOT_CLK_CFG, training_reg,
                       trainErr_reg, linkWidth_reg, linkSpeed_reg,
                       16'h0000};

    // ************************************************************
    // Phy link configuration
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            cfg0_reg <= PHY_CFG0_RST;
            cfg1_reg <= PHY_CFG1_RST;
            cfg2_reg <= PHY_CFG2_RST;
        end else if (wrEn) begin
            if (hit(OFF_PHY_CFG0)) begin
                cfg0_reg <= mergeBytes(cfg0_reg, avs_writedata,
                                       avs_byteenable, 32'hFFFF_FFFF);
            end
            if (hit(OFF_PHY_CFG1)) begin
                cfg1_reg <= mergeBytes(cfg1_reg, avs_writedata,
                                       avs_byteenable, 32'hFFFF_FFFF);
            end
            if (hit(OFF_PHY_CFG2)) begin
                cfg2_reg <= mergeBytes(cfg2_reg, avs_writedata,
                                       avs_byteenable, PHY_CFG2_WMSK);
            end
        end
    end

    assign hotResetEn      = cfg0_reg[C0_HOT_RST];
    assign loopbackEn      = cfg0_reg[C0_LOOPBACK];
    assign crossLinkEn     = cfg0_reg[C0_XLINK];
    assign laneNegTries    = cfg0_reg[C0_NEG_LSB +: 3];
    assign l1EntryTimer    = cfg0_reg[C0_L1T_LSB +: 16];
    assign lifetimeTimers  = cfg1_reg;
    assign cdrRecoveryFts  = cfg2_reg[C2_CDR_LSB +: 8];
    // Recovery time in symbols, for the transmitter's FTS counter
    assign cdrRecoverySymbols = {2'b00, cdrRecoveryFts}
                              * {7'h00, FTS_SYMBOLS};
    assign ftsCommaSym     = SYM_COMMA;
    assign ftsFillSym      = SYM_FTS;
    assign l0sExitLatency  = cfg2_reg[C2_L0S_LSB +: 7];
    assign polarityInvEn   = cfg2_reg[C2_POL_INV];
    assign l1ExitLatency   = cfg2_reg[C2_L1_LSB +: 7];
    assign powerDownWaitEn = cfg2_reg[C2_PD_WAIT];

    // ************************************************************
    // Product data EEPROM cycle
    // ************************************************************
    // Launch only from idle; writes during a cycle are dropped so a
    // poll loop cannot corrupt the address of a cycle in flight
    assign pdLaunch = wrEn & hit(OFF_PD_CAP) & avs_byteenable[3]
                    & (pdState_reg == PD_IDLE);
    assign pdDone   = (pdState_reg == PD_BUSY) & eeAck;

    // Stray acknowledge while idle is ignored


    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pdState_reg <= PD_IDLE;
        end else begin
            unique case (pdState_reg)
                PD_IDLE: begin
                    if (pdLaunch) begin
                        pdState_reg <= PD_BUSY;
                    end
                end
                PD_BUSY: begin
                    if (eeAck) begin
                        pdState_reg <= PD_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pdOp_reg   <= 1'b0;
        end else if (pdLaunch) begin
            pdOp_reg   <= avs_writedata[PD_OP_BIT];
        end else if (pdDone) begin
            pdOp_reg <= ~pdOp_reg;
        end
    end

    // Address lane may be written alone, without a launch
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pdAddr_reg <= 6'h00;
        end else if (wrEn && hit(OFF_PD_CAP) && avs_byteenable[2]
                     && pdState_reg == PD_IDLE) begin
            pdAddr_reg <= avs_writedata[PD_ADDR_LSB +: 6];
        end
    end


    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            pdData_reg <= PD_DATA_RST;
        end else if (pdDone && !pdOp_reg) begin
            pdData_reg <= eeRdata;
        end else if (wrEn && hit(OFF_PD_DATA)
                     && pdState_reg == PD_IDLE) begin
            pdData_reg <= mergeBytes(pdData_reg, avs_writedata,
                                     avs_byteenable, 32'hFFFF_FFFF);
        end
    end

    assign eeReq   = (pdState_reg == PD_BUSY);
    assign eeWrite = pdOp_reg;
    assign eeAddr  = pdAddr_reg;
    assign eeWdata = pdData_reg;

    assign pdCapWord = {pdOp_reg, 7'h00, pdAddr_reg, 2'b00,
                        PD_NEXT_PTR, PD_CAP_ID};

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign irqEvent[IRQ_RD_DONE]  = pdDone & ~pdOp_reg;
    assign irqEvent[IRQ_WR_DONE]  = pdDone & pdOp_reg;
    assign irqEvent[IRQ_LINK_CHG] = inactive_reg ^ linkInactiveIn;

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            irqStatus_reg <= '0;
            irqMask_reg   <= '0;
        end else begin
            if (wrEn && hit(OFF_IRQ_STATUS) && avs_byteenable[0]) begin
                irqStatus_reg <= (irqStatus_reg
                                 & ~avs_writedata[IRQ_W-1:0]) | irqEvent;
            end else begin
                irqStatus_reg <= irqStatus_reg | irqEvent;
            end
            if (wrEn && hit(OFF_IRQ_MASK) && avs_byteenable[0]) begin
                irqMask_reg <= avs_writedata[IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irqStatus_reg & irqMask_reg);

    // Level output; software clears the cause


    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit(OFF_LINK_STATUS)) begin
            rdata_next = linkWord;
        end
        if (hit(OFF_PHY_CFG0)) begin
            rdata_next = cfg0_reg;
        end
        if (hit(OFF_PHY_CFG1)) begin
            rdata_next = cfg1_reg;
        end
        if (hit(OFF_PHY_CFG2)) begin
            rdata_next = cfg2_reg;
        end
        if (hit(OFF_PD_CAP)) begin
            rdata_next = pdCapWord;
        end
        if (hit(OFF_PD_DATA) || hit(OFF_PD_DATA_ALT)) begin
            rdata_next = pdData_reg;
        end
        if (hit(OFF_IRQ_STATUS)) begin
            rdata_next = {{(32-IRQ_W){1'b0}}, irqStatus_reg};
        end
        if (hit(OFF_IRQ_MASK)) begin
            rdata_next = {{(32-IRQ_W){1'b0}}, irqMask_reg};
        end
    end

    // Captured in the wait cycle, stands until the next read
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            rdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            rdata_reg <= rdata_next;
        end
    end
    assign avs_readdata = rdata_reg;

    // Unmapped offsets read as zero


endmodule : lpc_regs

`default_nettype wire
